// >>> logic/amcl_defs.vh
// Constants for the converter mode and control logic.
// Assumes one 125 MHz clock; all pins synchronous to it.
// Notes on behaviour
// - Reference outputs toggle at sample clock over four
// - Alignment register bit 1 enables outputs; reset off
// - Follower aligns divider to reference input, delay adjustable
// - Pin mode: dual-edge pin selects interleaved sampling
// - Extended mode: interleave from main bit 7
// - Wait-select pin picks long or short calibration wait
// - Low then high on request starts calibration
// - Request high at power-on holds off auto calibration
// - Extended mode: request is pin OR bit 15
// - Trim active high exactly while calibration runs
// - Sleep pins power channels down in every mode
// - Extended mode: sleep OR bits 11 and 10
// - Pattern from pin, or only bit 12 extended
// - Unsplit output comes only from its pin
// - Span from pin, or per-channel registers extended
// - Strobe phase matters only in demultiplexed mode
// - Extended mode: phase from bit 14, reset zero
// - Enable low: serial register control active
// - Enable high: serial port off, registers defaulted
// - Select low shifts data; high tristates output
`ifndef AMCL_DEFS_VH
`define AMCL_DEFS_VH
`define AMCL_ADDR_MAIN      4'h0
`define AMCL_ADDR_SPAN_I    4'h3
`define AMCL_ADDR_SPAN_Q    4'hB
`define AMCL_ADDR_ALIGN     4'hE
`define AMCL_RST_MAIN       16'h0000
`define AMCL_RST_SPAN       16'h0000
`define AMCL_RST_ALIGN      16'h0000
`define AMCL_BIT_CAL        15
`define AMCL_BIT_PHASE      14
`define AMCL_BIT_PATTERN    12
`define AMCL_BIT_SLEEP_I    11
`define AMCL_BIT_SLEEP_Q    10
`define AMCL_BIT_INTERLEAVE 7
`define AMCL_BIT_REF_EN     1
`define AMCL_BIT_FOLLOWER   0
`define AMCL_DELAY_LSB      8
`define AMCL_FRAME_BITS     21
`define AMCL_WAIT_LONG      24'h000400
`define AMCL_WAIT_SHORT     24'h000100
`define AMCL_CAL_CYCLES     24'h000200
`endif

// >>> logic/amcl_serial_port.v
// Serial register port: one read/write flag, 4-bit address, 16-bit data.
// Assumes serial clock and select sampled in the system clock domain.
`timescale 1ns/1ps
`include "amcl_defs.vh"
module amcl_serial_port (
    clock,
    reset_n,
    port_enable,
    serial_select_n,
    serial_clock,
    serial_in,
    read_data,
    serial_out,
    serial_out_en,
    wr_strobe,
    wr_addr,
    wr_data,
    rd_addr
);
    input             clock;
    input             reset_n;
    input             port_enable;
    input             serial_select_n;
    input             serial_clock;
    input             serial_in;
    input      [15:0] read_data;
    output reg        serial_out;
    output reg        serial_out_en;
    output reg        wr_strobe;
    output reg [3:0]  wr_addr;
    output reg [15:0] wr_data;
    output     [3:0]  rd_addr;

    reg  [4:0]  count_r;
    reg  [20:0] shift_r;
    reg  [15:0] out_r;
    reg         sclk_d_r;
    wire        active;
    wire        rise;
    wire        fall;

    assign active  = port_enable & ~serial_select_n;
    assign rise    = serial_clock & ~sclk_d_r;
    assign fall    = ~serial_clock & sclk_d_r;
    assign rd_addr = {shift_r[2:0], serial_in};

    // ****************************************
    // Shift engine
    // ****************************************
    always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            count_r       <= 5'h00;
            shift_r       <= 21'h000000;
            out_r         <= 16'h0000;
            sclk_d_r      <= 1'b0;
            serial_out    <= 1'b0;
            serial_out_en <= 1'b0;
            wr_strobe     <= 1'b0;
            wr_addr       <= 4'h0;
            wr_data       <= 16'h0000;
        end else begin
            sclk_d_r      <= serial_clock;
            wr_strobe     <= 1'b0;
            serial_out_en <= active;
            if (!active) begin
                count_r <= 5'h00;
            end else if (rise && count_r < `AMCL_FRAME_BITS) begin
                shift_r <= {shift_r[19:0], serial_in};
                count_r <= count_r + 5'h01;
                if (count_r == 5'h04) begin
                    out_r <= read_data;
                end
                if (count_r == 5'h14 && !shift_r[19]) begin
                    wr_strobe <= 1'b1;
                    wr_addr   <= shift_r[18:15];
                    wr_data   <= {shift_r[14:0], serial_in};
                end
            end else if (fall && count_r > 5'h04) begin
                serial_out <= out_r[15];
                out_r      <= {out_r[14:0], 1'b0};
            end
        end
    end
endmodule // amcl_serial_port

// >>> logic/amcl_cal_seq.v
// Calibration sequencer: power-on wait, request edges, run period.
// Assumes request is already combined from pin and register bit.
`timescale 1ns/1ps
`include "amcl_defs.vh"
module amcl_cal_seq (
    clock,
    reset_n,
    cal_request,
    cal_wait_select,
    trim_active
);
    input      clock;
    input      reset_n;
    input      cal_request;
    input      cal_wait_select;
    output reg trim_active;

    localparam ST_START = 2'b00;
    localparam ST_WAIT  = 2'b01;
    localparam ST_IDLE  = 2'b10;
    localparam ST_RUN   = 2'b11;

    reg [1:0]  state_r;
    reg [23:0] count_r;
    reg        req_d_r;
    reg        armed_r;
    reg        hold_r;

    // ****************************************
    // Sequencer
    // ****************************************
    always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            state_r     <= ST_START;
            count_r     <= 24'h000000;
            req_d_r     <= 1'b0;
            armed_r     <= 1'b0;
            hold_r      <= 1'b0;
            trim_active <= 1'b0;
        end else begin
            req_d_r <= cal_request;
            if (!cal_request) begin
                armed_r <= 1'b1;
            end
            case (state_r)
                ST_START: begin
                    armed_r <= ~cal_request;
                    hold_r  <= cal_request;
                    count_r <= cal_wait_select ? `AMCL_WAIT_LONG : `AMCL_WAIT_SHORT;
                    state_r <= ST_WAIT;
                end
                ST_WAIT: begin
                    if (hold_r) begin
                        if (armed_r && cal_request && !req_d_r) begin
                            count_r     <= `AMCL_CAL_CYCLES;
                            trim_active <= 1'b1;
                            armed_r     <= 1'b0;
                            hold_r      <= 1'b0;
                            state_r     <= ST_RUN;
                        end
                    end else if (count_r == 24'h000000) begin
                        count_r     <= `AMCL_CAL_CYCLES;
                        trim_active <= 1'b1;
                        state_r     <= ST_RUN;
                    end else begin
                        count_r <= count_r - 24'h000001;
                    end
                end
                ST_IDLE: begin
                    if (armed_r && cal_request && !req_d_r) begin
                        count_r     <= `AMCL_CAL_CYCLES;
                        trim_active <= 1'b1;
                        armed_r     <= 1'b0;
                        state_r     <= ST_RUN;
                    end
                end
                ST_RUN: begin
                    if (count_r == 24'h000000) begin
                        trim_active <= 1'b0;
                        armed_r     <= ~cal_request;
                        state_r     <= ST_IDLE;
                    end else begin
                        count_r <= count_r - 24'h000001;
                    end
                end
                default: state_r <= ST_START;
            endcase
        end
    end
endmodule // amcl_cal_seq

// >>> logic/amcl_top.v
// Mode and control logic: pin or register selected modes, reference outputs.
// Assumes all pins synchronous to the 125 MHz clock.
`timescale 1ns/1ps
`include "amcl_defs.vh"
module amcl_top (
    clock,
    reset_n,
    ext_ctrl_enable_n,
    dual_edge_sampling_select,
    cal_wait_select,
    trim_cycle_request,
    chan_i_sleep,
    chan_q_sleep,
    fixed_pattern_select,
    output_unsplit_select,
    input_span_select,
    strobe_phase_select,
    sync_ref_in,
    serial_select_n,
    serial_clock,
    serial_in,
    serial_out,
    serial_out_en,
    trim_active,
    interleave_mode,
    chan_i_power_down,
    chan_q_power_down,
    pattern_mode,
    unsplit_mode,
    span_i,
    span_q,
    strobe_phase_90,
    sync_ref_out_a,
    sync_ref_out_b,
    ref_delay
);
    input             clock;
    input             reset_n;
    input             ext_ctrl_enable_n;
    input             dual_edge_sampling_select;
    input             cal_wait_select;
    input             trim_cycle_request;
    input             chan_i_sleep;
    input             chan_q_sleep;
    input             fixed_pattern_select;
    input             output_unsplit_select;
    input             input_span_select;
    input             strobe_phase_select;
    input             sync_ref_in;
    input             serial_select_n;
    input             serial_clock;
    input             serial_in;
    output            serial_out;
    output            serial_out_en;
    output            trim_active;
    output reg        interleave_mode;
    output reg        chan_i_power_down;
    output reg        chan_q_power_down;
    output reg        pattern_mode;
    output reg        unsplit_mode;
    output reg [15:0] span_i;
    output reg [15:0] span_q;
    output reg        strobe_phase_90;
    output reg        sync_ref_out_a;
    output reg        sync_ref_out_b;
    output reg [7:0]  ref_delay;

    reg  [15:0] main_mode_control_r;
    reg  [15:0] i_channel_input_range_r;
    reg  [15:0] q_channel_input_range_r;
    reg  [15:0] multi_chip_alignment_control_r;
    reg  [1:0]  div_r;
    reg         ref_in_d_r;
    reg  [15:0] rd_data;
    wire        extended_control_mode;
    wire        wr_strobe;
    wire [3:0]  wr_addr;
    wire [15:0] wr_data;
    wire [3:0]  rd_addr;
    wire        follower;

    assign extended_control_mode = ~ext_ctrl_enable_n;
    assign follower = multi_chip_alignment_control_r[`AMCL_BIT_FOLLOWER];

    // ****************************************
    // Serial port and calibration
    // ****************************************
    amcl_serial_port u_port (
        .clock           (clock),
        .reset_n         (reset_n),
        .port_enable     (extended_control_mode),
        .serial_select_n (serial_select_n),
        .serial_clock    (serial_clock),
        .serial_in       (serial_in),
        .read_data       (rd_data),
        .serial_out      (serial_out),
        .serial_out_en   (serial_out_en),
        .wr_strobe       (wr_strobe),
        .wr_addr         (wr_addr),
        .wr_data         (wr_data),
        .rd_addr         (rd_addr)
    );

    amcl_cal_seq u_cal (
        .clock           (clock),
        .reset_n         (reset_n),
        .cal_request     (trim_cycle_request |
                          (extended_control_mode & main_mode_control_r[`AMCL_BIT_CAL])),
        .cal_wait_select (cal_wait_select),
        .trim_active     (trim_active)
    );

    always @* begin
        case (rd_addr)
            `AMCL_ADDR_MAIN:   rd_data = main_mode_control_r;
            `AMCL_ADDR_SPAN_I: rd_data = i_channel_input_range_r;
            `AMCL_ADDR_SPAN_Q: rd_data = q_channel_input_range_r;
            `AMCL_ADDR_ALIGN:  rd_data = multi_chip_alignment_control_r;
            default:           rd_data = 16'h0000;
        endcase
    end

    // ****************************************
    // Register bank
    // ****************************************
    always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            main_mode_control_r            <= `AMCL_RST_MAIN;
            i_channel_input_range_r        <= `AMCL_RST_SPAN;
            q_channel_input_range_r        <= `AMCL_RST_SPAN;
            multi_chip_alignment_control_r <= `AMCL_RST_ALIGN;
        end else if (!extended_control_mode) begin
            main_mode_control_r            <= `AMCL_RST_MAIN;
            i_channel_input_range_r        <= `AMCL_RST_SPAN;
            q_channel_input_range_r        <= `AMCL_RST_SPAN;
            multi_chip_alignment_control_r <= `AMCL_RST_ALIGN;
        end else if (wr_strobe) begin
            case (wr_addr)
                `AMCL_ADDR_MAIN:   main_mode_control_r <= wr_data;
                `AMCL_ADDR_SPAN_I: i_channel_input_range_r <= wr_data;
                `AMCL_ADDR_SPAN_Q: q_channel_input_range_r <= wr_data;
                `AMCL_ADDR_ALIGN:  multi_chip_alignment_control_r <= wr_data;
                default:           main_mode_control_r <= main_mode_control_r;
            endcase
        end
    end

    // ****************************************
    // Mode selection
    // ****************************************
    always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            interleave_mode   <= 1'b0;
            chan_i_power_down <= 1'b0;
            chan_q_power_down <= 1'b0;
            pattern_mode      <= 1'b0;
            unsplit_mode      <= 1'b0;
            span_i            <= 16'h0000;
            span_q            <= 16'h0000;
            strobe_phase_90   <= 1'b0;
            ref_delay         <= 8'h00;
        end else if (extended_control_mode) begin
            interleave_mode   <= main_mode_control_r[`AMCL_BIT_INTERLEAVE];
            chan_i_power_down <= chan_i_sleep | main_mode_control_r[`AMCL_BIT_SLEEP_I];
            chan_q_power_down <= chan_q_sleep | main_mode_control_r[`AMCL_BIT_SLEEP_Q];
            pattern_mode      <= main_mode_control_r[`AMCL_BIT_PATTERN];
            unsplit_mode      <= output_unsplit_select;
            span_i            <= i_channel_input_range_r;
            span_q            <= q_channel_input_range_r;
            strobe_phase_90   <= ~output_unsplit_select &
                                 main_mode_control_r[`AMCL_BIT_PHASE];
            ref_delay         <= multi_chip_alignment_control_r[15:8];
        end else begin
            interleave_mode   <= dual_edge_sampling_select;
            chan_i_power_down <= chan_i_sleep;
            chan_q_power_down <= chan_q_sleep;
            pattern_mode      <= fixed_pattern_select;
            unsplit_mode      <= output_unsplit_select;
            span_i            <= {15'h0000, input_span_select};
            span_q            <= {15'h0000, input_span_select};
            strobe_phase_90   <= ~output_unsplit_select & strobe_phase_select;
            ref_delay         <= 8'h00;
        end
    end

    // ****************************************
    // Reference clock divider
    // ****************************************
    always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            div_r          <= 2'b00;
            ref_in_d_r     <= 1'b0;
            sync_ref_out_a <= 1'b0;
            sync_ref_out_b <= 1'b0;
        end else begin
            ref_in_d_r <= sync_ref_in;
            if (follower && sync_ref_in && !ref_in_d_r) begin
                div_r <= 2'b01;
            end else begin
                div_r <= div_r + 2'b01;
            end
            if (multi_chip_alignment_control_r[`AMCL_BIT_REF_EN]) begin
                sync_ref_out_a <= ~div_r[1];
                sync_ref_out_b <= ~div_r[1];
            end else begin
                sync_ref_out_a <= 1'b0;
                sync_ref_out_b <= 1'b0;
            end
        end
    end
endmodule // amcl_top

// >>> tb/amcl_host.sv
// Serial host model: drives register frames into the control port.
// Assumes frames of one read flag, four address bits, sixteen data bits.
`timescale 1ns/1ps
module amcl_host (
    input  logic clock,
    input  logic serial_out,
    output logic serial_select_n,
    output logic serial_clock,
    output logic serial_in
);
    initial begin
        serial_select_n = 1'b1;
        serial_clock    = 1'b0;
        serial_in       = 1'b0;
    end

    // One whole frame; read data sampled before each rising clock
    task frame(input logic rd, input logic [3:0] addr, input logic [15:0] wdata,
               output logic [15:0] rdata);
        logic [20:0] bits;
        integer      n;
        bits  = {rd, addr, wdata};
        rdata = 16'h0000;
        @(negedge clock);
        serial_select_n = 1'b0;
        for (n = 20; n >= 0; n = n - 1) begin
            serial_in = bits[n];
            repeat (3) @(negedge clock);
            if (n < 16)
                rdata[n] = serial_out;
            serial_clock = 1'b1;
            repeat (2) @(negedge clock);
            serial_clock = 1'b0;
        end
        repeat (4) @(negedge clock);
        serial_select_n = 1'b1;
        serial_in       = ~serial_in;
        repeat (2) @(negedge clock);
    endtask
endmodule // amcl_host

// >>> tb/amcl_top_monitor.sv
// Checker for the converter mode and control logic.
// Assumes binding to amcl_top; sees only its ports.
`timescale 1ns/1ps
module amcl_top_monitor (
    input logic        clock,
    input logic        reset_n,
    input logic        ext_ctrl_enable_n,
    input logic        dual_edge_sampling_select,
    input logic        chan_i_sleep,
    input logic        chan_q_sleep,
    input logic        output_unsplit_select,
    input logic        input_span_select,
    input logic        serial_select_n,
    input logic        serial_out_en,
    input logic        trim_active,
    input logic        interleave_mode,
    input logic        chan_i_power_down,
    input logic        chan_q_power_down,
    input logic        unsplit_mode,
    input logic [15:0] span_i,
    input logic [15:0] span_q,
    input logic        strobe_phase_90,
    input logic        sync_ref_out_a,
    input logic        sync_ref_out_b,
    input logic [7:0]  ref_delay
);
    default clocking @(posedge clock); endclocking
    default disable iff (!reset_n);
    logic [15:0] run_r;

    // Cycles spent with calibration running
    always @(posedge clock or negedge reset_n) begin
        if (!reset_n)
            run_r <= 16'h0000;
        else if (trim_active)
            run_r <= run_r + 16'h0001;
        else
            run_r <= 16'h0000;
    end

    ref_pair_a: assert property (sync_ref_out_a == sync_ref_out_b)
        else $error("reference outputs differ");
    ref_high_a: assert property (sync_ref_out_a && $past(sync_ref_out_a) |=> !sync_ref_out_a)
        else $error("reference high too long");
    ref_low_a: assert property ($fell(sync_ref_out_a) |=> !sync_ref_out_a)
        else $error("reference low too short");
    pin_des_a: assert property (ext_ctrl_enable_n |=>
        interleave_mode == $past(dual_edge_sampling_select))
        else $error("interleave does not follow pin");
    sleep_i_a: assert property (chan_i_sleep |=> chan_i_power_down)
        else $error("i channel not powered down");
    sleep_q_a: assert property (chan_q_sleep |=> chan_q_power_down)
        else $error("q channel not powered down");
    unsplit_pin_a: assert property (1'b1 |=> unsplit_mode == $past(output_unsplit_select))
        else $error("unsplit mode does not follow pin");
    phase_demux_a: assert property (output_unsplit_select |=> !strobe_phase_90)
        else $error("phase set in unsplit mode");
    span_pin_a: assert property (ext_ctrl_enable_n |=>
        span_i == {15'h0000, $past(input_span_select)} && span_q == span_i)
        else $error("span does not follow pin");
    port_off_a: assert property (ext_ctrl_enable_n || serial_select_n |=> !serial_out_en)
        else $error("serial output driven when idle");
    run_len_a: assert property (trim_active |-> run_r < 16'h0201)
        else $error("calibration runs too long");
    run_end_a: assert property ($fell(trim_active) |-> run_r == 16'h0201)
        else $error("calibration run length wrong");
    delay_pin_a: assert property (ext_ctrl_enable_n |=> ref_delay == 8'h00)
        else $error("delay kept in pin mode");
endmodule // amcl_top_monitor

bind amcl_top amcl_top_monitor mon (.clock(clock), .reset_n(reset_n),
    .ext_ctrl_enable_n(ext_ctrl_enable_n), .dual_edge_sampling_select(dual_edge_sampling_select),
    .chan_i_sleep(chan_i_sleep), .chan_q_sleep(chan_q_sleep),
    .output_unsplit_select(output_unsplit_select), .input_span_select(input_span_select),
    .serial_select_n(serial_select_n), .serial_out_en(serial_out_en),
    .trim_active(trim_active), .interleave_mode(interleave_mode),
    .chan_i_power_down(chan_i_power_down), .chan_q_power_down(chan_q_power_down),
    .unsplit_mode(unsplit_mode), .span_i(span_i), .span_q(span_q),
    .strobe_phase_90(strobe_phase_90), .sync_ref_out_a(sync_ref_out_a),
    .sync_ref_out_b(sync_ref_out_b), .ref_delay(ref_delay));

// >>> tb/amcl_top_tb.sv
// Testbench for the converter mode and control logic.
// Assumes the serial host model and the bound checker.
`timescale 1ns/1ps
module amcl_top_tb;
    logic        clock   = 1'b0;
    logic        reset_n = 1'b0;
    logic        ext_n   = 1'b1;
    logic        cwait   = 1'b0;
    logic        creq    = 1'b0;
    logic        p;
    logic        sref    = 1'b0;
    logic [6:0]  pins    = 7'h00;
    logic [15:0] rd;
    wire         ssn, sclk, sin, sout, sout_en, trim, ra, rb;
    wire  [6:0]  mode;
    wire  [15:0] spi_, spq;
    wire  [7:0]  rdel;
    integer      n_fail = 0;
    integer      checks = 0;
    integer      n, rises;
    // Rows: {dual, pattern, unsplit, span, phase, i sleep, q sleep} then outputs
    logic [13:0] rows [0:4] = '{14'h0000, 14'h3FFB, 14'h2AD1, 14'h152A, 14'h0A10};

    always #4 clock = ~clock;
    assign mode[3] = spi_[0];

    amcl_top dut (.clock(clock), .reset_n(reset_n), .ext_ctrl_enable_n(ext_n),
        .dual_edge_sampling_select(pins[6]), .cal_wait_select(cwait),
        .trim_cycle_request(creq), .chan_i_sleep(pins[1]), .chan_q_sleep(pins[0]),
        .fixed_pattern_select(pins[5]), .output_unsplit_select(pins[4]),
        .input_span_select(pins[3]), .strobe_phase_select(pins[2]), .sync_ref_in(sref),
        .serial_select_n(ssn), .serial_clock(sclk), .serial_in(sin), .serial_out(sout),
        .serial_out_en(sout_en), .trim_active(trim), .interleave_mode(mode[6]),
        .chan_i_power_down(mode[1]), .chan_q_power_down(mode[0]), .pattern_mode(mode[5]),
        .unsplit_mode(mode[4]), .span_i(spi_), .span_q(spq), .strobe_phase_90(mode[2]),
        .sync_ref_out_a(ra), .sync_ref_out_b(rb), .ref_delay(rdel));

    amcl_host host (.clock(clock), .serial_out(sout_en ? sout : 1'bz),
        .serial_select_n(ssn), .serial_clock(sclk), .serial_in(sin));

    task check(input logic [31:0] seen, input logic [31:0] exp);
        checks = checks + 1;
        if (seen !== exp) begin
            n_fail = n_fail + 1;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task complete_run;
        if (n_fail == 0 && checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task wait_trim(input logic lvl, input integer bound, output integer cnt);
        cnt = 0;
        while (trim !== lvl) begin
            @(negedge clock);
            cnt = cnt + 1;
            if (cnt > bound) begin
                n_fail = n_fail + 1;
                $display("MISMATCH %0t calibration wait timed out", $time);
                complete_run;
            end
        end
    endtask

    task do_reset(input logic w, input logic q);
        reset_n = 1'b0;
        cwait   = w;
        creq    = q;
        repeat (10) @(negedge clock);
        reset_n = 1'b1;
    endtask

    task wr(input logic [3:0] a, input logic [15:0] d);
        host.frame(1'b0, a, d, rd);
        repeat (3) @(negedge clock);
    endtask

    task rd_reg(input logic [3:0] a);
        host.frame(1'b1, a, 16'h0000, rd);
    endtask

    initial begin
        // **********************************
        // Power-on calibration and pin modes
        // **********************************
        do_reset(1'b0, 1'b0);
        check({ra, rb}, 2'b00);
        wait_trim(1'b1, 2000, n);
        check(n, 258);
        wait_trim(1'b0, 2000, n);
        check(n, 513);
        for (n = 0; n < 5; n = n + 1) begin
            pins = rows[n][13:7];
            repeat (2) @(negedge clock);
            check(mode, rows[n][6:0]);
            check(spq, {15'h0000, pins[3]});
        end
        creq = 1'b1;
        wait_trim(1'b1, 20, n);
        check(trim, 1'b1);
        wait_trim(1'b0, 600, n);
        creq = 1'b0;
        // **********************************
        // Register control
        // **********************************
        pins  = 7'h6C;
        ext_n = 1'b0;
        repeat (2) @(negedge clock);
        check(mode, 7'h00);
        wr(4'h0, 16'h5C80);
        check(mode, 7'h67);
        rd_reg(4'h0);
        check(rd, 16'h5C80);
        wr(4'h3, 16'hA5C3);
        wr(4'hB, 16'h3C5A);
        check({spi_, spq}, 32'hA5C33C5A);
        rd_reg(4'hB);
        check(rd, 16'h3C5A);
        wr(4'hE, 16'h2A03);
        check(rdel, 8'h2A);
        rises = 0;
        repeat (40) begin
            p = ra;
            @(negedge clock);
            if (ra === 1'b1 && p === 1'b0)
                rises = rises + 1;
        end
        check(rises, 10);
        for (n = 0; n < 8 && !(p === 1'b1 && ra === 1'b0); n = n + 1) begin
            p = ra;
            @(negedge clock);
        end
        sref = 1'b1;
        repeat (2) @(negedge clock);
        for (n = 0; n < 4; n = n + 1) begin
            rd[n] = ra;
            @(negedge clock);
        end
        check(rd[3:0], 4'h9);
        wr(4'h0, 16'h8000);
        wait_trim(1'b1, 60, n);
        check(trim, 1'b1);
        wait_trim(1'b0, 600, n);
        ext_n = 1'b1;
        repeat (3) @(negedge clock);
        check({ra, rb, rdel, spi_}, 26'h0000001);
        ext_n = 1'b0;
        repeat (2) @(negedge clock);
        rd_reg(4'h0);
        check(rd, 16'h0000);
        // **********************************
        // Long wait and held request
        // **********************************
        do_reset(1'b1, 1'b0);
        wait_trim(1'b1, 2000, n);
        check(n, 1026);
        wait_trim(1'b0, 600, n);
        do_reset(1'b0, 1'b1);
        repeat (400) @(negedge clock);
        check(trim, 1'b0);
        repeat (2) begin
            creq = 1'b0;
            repeat (4) @(negedge clock);
            creq = 1'b1;
            repeat (4) @(negedge clock);
        end
        wait_trim(1'b1, 20, n);
        check(trim, 1'b1);
        complete_run;
    end
endmodule // amcl_top_tb
